// file: hw/mash_regs.sv
`timescale 1ns/1ps
`include "mash_defs.svh"
module mash_regs import mash_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // axi4-lite write
    input wire logic [9:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read
    input wire logic [9:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // converter side
    input wire logic i_adc_valid,
    input wire mash_sample_t i_adc_sample,
    input wire logic i_temp_valid,
    input wire logic [11:0] i_temp_code,
    input wire logic i_seq_start,
    input wire logic i_seq_done,
    output logic [11:0] o_output_code [12],
    output logic [11:0] o_output_clear,
    output logic [3:0] o_group_half_range,
    output logic o_temp_sensor_en,
    // general purpose pins, open drain
    input wire logic [7:0] i_gpio,
    output logic [7:0] o_gpio,
    output logic [7:0] o_gpio_oe
);
    localparam logic [11:0] THERM_SET = 12'(`MASH_THERM_SET_DEGC
        * `MASH_TEMP_LSB_PER_DEGC);
    localparam logic [11:0] THERM_CLR = 12'((`MASH_THERM_SET_DEGC
        - `MASH_THERM_HYST_DEGC) * `MASH_TEMP_LSB_PER_DEGC);

    // register state
    logic [3:0] adc_cfg_q, adc_cfg_d;
    logic [4:0] falarm_q, falarm_d;
    logic [3:0] pin_fn_q, pin_fn_d;
    logic [1:0] mux2_q, mux2_d;
    logic [11:0] clren_q, clren_d;
    mash_alarm_t clrsrc_q, clrsrc_d, pinsrc_q, pinsrc_d;
    logic latch_dis_q, latch_dis_d;
    logic [3:0] range_q, range_d;
    logic [11:0] dac_q [12];
    logic [11:0] dac_d [12];
    logic [11:0] adc_q [17];
    logic [11:0] adc_d [17];
    logic [11:0] thr_up_q [6];
    logic [11:0] thr_up_d [6];
    logic [11:0] thr_lo_q [6];
    logic [11:0] thr_lo_d [6];
    logic [11:0] temp_q, temp_d;
    logic [7:0] gpio_wr_q, gpio_wr_d;
    // alarm state
    mash_count_t cnt_q [7];
    mash_count_t cnt_d [7];
    logic [6:0] qual_q, qual_d;
    logic therm_q, therm_d;
    mash_alarm_t stat_q, stat_d;
    logic data_available_flag_q, data_available_flag_d;
    // pin sampling
    logic [7:0] sync1_q, sync2_q, sync3_q, pin_q, pin_d;
    // bus state
    logic [7:0] aw_idx_q, aw_idx_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [7:0] rdata_q, rdata_d;
    logic [11:0] clear_q, clear_d;
    logic [7:0] oe_q, oe_d;

    // N consecutive samples for the channel count code
    function automatic mash_count_t chan_count(input logic [2:0] code);
        chan_count = (code == 3'h0) ? 9'h001 : 9'(9'h002 << code);
    endfunction

    function automatic mash_count_t temp_count(input logic [1:0] code);
        temp_count = 9'(9'h001 << code);
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx >= `MASH_IDX_ADC_CFG && idx <= `MASH_IDX_FALARM+8'h01)
            || idx == `MASH_IDX_MUX2
            || (idx >= `MASH_IDX_CLREN0 && idx <= `MASH_IDX_RANGE)
            || (idx >= `MASH_IDX_ADC_FIRST && idx <= `MASH_IDX_ADC_LAST)
            || (idx >= `MASH_IDX_DAC_FIRST && idx <= `MASH_IDX_DAC_LAST)
            || (idx >= `MASH_IDX_STAT0 && idx <= `MASH_IDX_GEN_STAT)
            || (idx >= `MASH_IDX_TEMP_LO && idx <= `MASH_IDX_GPIO)
            || (idx >= `MASH_IDX_THR_FIRST && idx <= `MASH_IDX_THR_LAST);
    endfunction

    // 12-bit value split into a low byte / high nibble pair
    function automatic logic [7:0] half(input logic [11:0] v,
                                        input logic hi);
        half = hi ? {4'h0, v[11:8]} : v[7:0];
    endfunction

    function automatic logic [11:0] put(input logic [11:0] v,
                                        input logic hi,
                                        input logic [7:0] b);
        put = hi ? {b[3:0], v[7:0]} : {v[11:8], b};
    endfunction

    logic [7:0] rd_val;
    logic [7:0] ar_idx;
    logic [7:0] off;
    logic [7:0] woff;
    logic ar_take, wr_go, hit, oor;
    logic [9:0] cnt_inc;
    mash_alarm_t set_ev, lvl, rd_clr;
    logic [11:0] code;
    logic signed [11:0] tcode;

    always_comb begin
        ar_idx = i_araddr[9:2];
        off = 8'h00;
        rd_val = 8'h00;
        if (ar_idx >= `MASH_IDX_ADC_FIRST && ar_idx <= `MASH_IDX_ADC_LAST)
        begin
            off = ar_idx - `MASH_IDX_ADC_FIRST;
            rd_val = half(adc_q[off[5:1]], off[0]);
        end else if (ar_idx >= `MASH_IDX_DAC_FIRST
                     && ar_idx <= `MASH_IDX_DAC_LAST) begin
            off = ar_idx - `MASH_IDX_DAC_FIRST;
            rd_val = half(dac_q[off[4:1]], off[0]);
        end else if (ar_idx >= `MASH_IDX_THR_FIRST
                     && ar_idx <= `MASH_IDX_THR_LAST) begin
            off = ar_idx - `MASH_IDX_THR_FIRST;
            rd_val = half(off[1] ? thr_lo_q[off[4:2]] : thr_up_q[off[4:2]],
                          off[0]);
        end else begin
            case (ar_idx)
                `MASH_IDX_ADC_CFG: rd_val = {adc_cfg_q, 4'h0};
                `MASH_IDX_FALARM: rd_val = {falarm_q, 3'h0};
                `MASH_IDX_PIN_FN: rd_val = {4'h0, pin_fn_q};
                `MASH_IDX_MUX2: rd_val = {6'h00, mux2_q};
                `MASH_IDX_CLREN0: rd_val = clren_q[7:0];
                `MASH_IDX_CLREN1: rd_val = {4'h0, clren_q[11:8]};
                `MASH_IDX_CLRSRC0: rd_val = {3'h0, clrsrc_q[4:0]};
                `MASH_IDX_CLRSRC1: rd_val = {4'h0, clrsrc_q[8:5]};
                `MASH_IDX_PINSRC0: rd_val = {3'h0, pinsrc_q[4:0]};
                `MASH_IDX_PINSRC1: rd_val = {3'h0, latch_dis_q, pinsrc_q[8:5]};
                `MASH_IDX_RANGE: rd_val = {4'h0, range_q};
                `MASH_IDX_STAT0: rd_val = {3'h0, stat_q[4:0]};
                `MASH_IDX_STAT1: rd_val = {4'h0, stat_q[8:5]};
                `MASH_IDX_GEN_STAT:
                    rd_val = {6'h00, |stat_q, data_available_flag_q};
                `MASH_IDX_TEMP_LO: rd_val = temp_q[7:0];
                `MASH_IDX_TEMP_HI: rd_val = {4'h0, temp_q[11:8]};
                `MASH_IDX_GPIO: rd_val = pin_q;
                default: rd_val = 8'h00;
            endcase
        end
    end

    always_comb begin
        // bus handshakes
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        aw_idx_d = aw_idx_q;
        wbyte_d = wbyte_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (i_awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            aw_idx_d = i_awaddr[9:2];
        end
        if (i_wvalid && !w_have_q) begin
            w_have_d = 1'b1;
            wbyte_d = i_wdata[7:0];
            wlane_d = i_wstrb[0];
        end
        if (bvalid_q && i_bready)
            bvalid_d = 1'b0;
        wr_go = aw_have_q && w_have_q && !bvalid_q;
        if (wr_go) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mapped(aw_idx_q) ? 2'b00 : 2'b10;
        end
        if (rvalid_q && i_rready)
            rvalid_d = 1'b0;
        ar_take = i_arvalid && !rvalid_q;
        if (ar_take) begin
            rvalid_d = 1'b1;
            rdata_d = rd_val;
            rresp_d = mapped(ar_idx) ? 2'b00 : 2'b10;
        end

        // register writes, byte lane 0 only
        adc_cfg_d = adc_cfg_q;
        falarm_d = falarm_q;
        pin_fn_d = pin_fn_q;
        mux2_d = mux2_q;
        clren_d = clren_q;
        clrsrc_d = clrsrc_q;
        pinsrc_d = pinsrc_q;
        latch_dis_d = latch_dis_q;
        range_d = range_q;
        gpio_wr_d = gpio_wr_q;
        dac_d = dac_q;
        thr_up_d = thr_up_q;
        thr_lo_d = thr_lo_q;
        woff = 8'h00;
        if (wr_go && wlane_q) begin
            if (aw_idx_q >= `MASH_IDX_DAC_FIRST
                && aw_idx_q <= `MASH_IDX_DAC_LAST) begin
                woff = aw_idx_q - `MASH_IDX_DAC_FIRST;
                dac_d[woff[4:1]] = put(dac_q[woff[4:1]], woff[0],
                                       wbyte_q);
            end else if (aw_idx_q >= `MASH_IDX_THR_FIRST
                         && aw_idx_q <= `MASH_IDX_THR_LAST) begin
                woff = aw_idx_q - `MASH_IDX_THR_FIRST;
                if (woff[1])
                    thr_lo_d[woff[4:2]] = put(thr_lo_q[woff[4:2]], woff[0],
                                              wbyte_q);
                else
                    thr_up_d[woff[4:2]] = put(thr_up_q[woff[4:2]], woff[0],
                                              wbyte_q);
            end else begin
                case (aw_idx_q)
                    `MASH_IDX_ADC_CFG: adc_cfg_d = wbyte_q[7:4];
                    `MASH_IDX_FALARM: falarm_d = wbyte_q[7:3];
                    `MASH_IDX_PIN_FN: pin_fn_d = wbyte_q[3:0];
                    `MASH_IDX_MUX2: mux2_d = wbyte_q[1:0];
                    `MASH_IDX_CLREN0: clren_d[7:0] = wbyte_q;
                    `MASH_IDX_CLREN1: clren_d[11:8] = wbyte_q[3:0];
                    `MASH_IDX_CLRSRC0: clrsrc_d[4:0] = wbyte_q[4:0];
                    `MASH_IDX_CLRSRC1: clrsrc_d[8:5] = wbyte_q[3:0];
                    `MASH_IDX_PINSRC0: pinsrc_d[4:0] = wbyte_q[4:0];
                    `MASH_IDX_PINSRC1: begin
                        pinsrc_d[8:5] = wbyte_q[3:0];
                        latch_dis_d = wbyte_q[4];
                    end
                    `MASH_IDX_RANGE: range_d = wbyte_q[3:0];
                    `MASH_IDX_GPIO: gpio_wr_d = wbyte_q;
                    default: ;
                endcase
            end
        end

        // converter results, ignored for unknown channels
        adc_d = adc_q;
        temp_d = temp_q;
        if (i_adc_valid && i_adc_sample.chan <= 5'd16)
            adc_d[i_adc_sample.chan] = i_adc_sample.code;
        if (i_temp_valid)
            temp_d = i_temp_code;

        // consecutive-sample qualification per monitored input
        cnt_d = cnt_q;
        qual_d = qual_q;
        set_ev = '0;
        for (int k = 0; k < 7; k++) begin
            code = (k < 5) ? i_adc_sample.code : i_temp_code;
            tcode = i_temp_code;
            if (k < 5) begin
                hit = i_adc_valid && i_adc_sample.chan
                    == 5'(`MASH_FIRST_MON_CHAN + 5'(k));
                oor = thr_up_q[k] <= thr_lo_q[k] || code > thr_up_q[k]
                    || code < thr_lo_q[k];
            end else begin
                hit = i_temp_valid && mux2_q[`MASH_MUX2_TEMP_EN];
                oor = $signed(thr_up_q[5]) <= $signed(thr_lo_q[5])
                    || ((k == 5) ? tcode < $signed(thr_lo_q[5])
                                 : tcode > $signed(thr_up_q[5]));
            end
            cnt_inc = {1'b0, cnt_q[k]} + 10'h001;
            if (hit) begin
                if (oor) begin
                    cnt_d[k] = (cnt_inc > 10'h100) ? 9'h100 : cnt_inc[8:0];
                    if (cnt_inc[8:0] >= ((k < 5) ? chan_count(falarm_q[4:2])
                                         : temp_count(falarm_q[1:0]))
                        || cnt_inc[9]) begin
                        qual_d[k] = 1'b1;
                        set_ev[k] = 1'b1;
                    end
                end else begin
                    cnt_d[k] = 9'h000;
                    qual_d[k] = 1'b0;
                end
            end
        end

        // thermal trip with hysteresis, tracked on each temperature sample
        therm_d = therm_q;
        if (i_temp_valid) begin
            if ($signed(i_temp_code) >= $signed(THERM_SET))
                therm_d = 1'b1;
            else if ($signed(i_temp_code) < $signed(THERM_CLR))
                therm_d = 1'b0;
        end
        if (!mux2_q[`MASH_MUX2_TEMP_EN])
            therm_d = 1'b0;

        // status bits; a set arriving with the read-clear wins
        lvl = {pin_fn_q[`MASH_PIN_ALARM_IN] && pin_q[`MASH_PIN_ALARM_IN],
               therm_q, qual_q};
        set_ev[8:7] = lvl[8:7];
        rd_clr = '0;
        if (ar_take && ar_idx == `MASH_IDX_STAT0)
            rd_clr[4:0] = 5'h1F;
        if (ar_take && ar_idx == `MASH_IDX_STAT1)
            rd_clr[8:5] = 4'hF;
        if (latch_dis_q)
            stat_d = lvl;
        else
            stat_d = set_ev | (stat_q & ~(rd_clr & ~lvl));
        if (!mux2_q[`MASH_MUX2_TEMP_EN])
            stat_d[7] = 1'b0;

        // one-shot data available flag
        if (adc_cfg_q[`MASH_CFG_AUTO_MODE])
            data_available_flag_d = 1'b0;
        else if (i_seq_done)
            data_available_flag_d = 1'b1;
        else if (i_seq_start)
            data_available_flag_d = 1'b0;
        else
            data_available_flag_d = data_available_flag_q;

        // output clear and open-drain pin drive
        clear_d = clren_q & {12{|(stat_q & clrsrc_q)}};
        oe_d = ~gpio_wr_q;
        if (pin_fn_q[`MASH_PIN_ALARM_IN])
            oe_d[`MASH_PIN_ALARM_IN] = 1'b0;
        if (pin_fn_q[`MASH_PIN_ALARM_OUT])
            oe_d[`MASH_PIN_ALARM_OUT] =
                |(stat_q & pinsrc_q);

        // pin levels accepted once the last two stages agree
        pin_d = (sync2_q == sync3_q) ? sync3_q : pin_q;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            adc_cfg_q <= 4'h0;
            falarm_q <= `MASH_FALARM_RESET;
            pin_fn_q <= 4'h0;
            mux2_q <= 2'h0;
            clren_q <= 12'h000;
            clrsrc_q <= '0;
            pinsrc_q <= '0;
            latch_dis_q <= 1'b0;
            range_q <= 4'h0;
            gpio_wr_q <= `MASH_GPIO_RESET;
            for (int i = 0; i < 12; i++)
                dac_q[i] <= 12'h000;
            for (int i = 0; i < 17; i++)
                adc_q[i] <= 12'h000;
            for (int i = 0; i < 5; i++) begin
                thr_up_q[i] <= `MASH_THR_UP_RESET;
                thr_lo_q[i] <= `MASH_THR_LO_RESET;
            end
            thr_up_q[5] <= `MASH_TEMP_UP_RESET;
            thr_lo_q[5] <= `MASH_TEMP_LO_RESET;
            temp_q <= 12'h000;
            for (int i = 0; i < 7; i++)
                cnt_q[i] <= 9'h000;
            qual_q <= 7'h00;
            therm_q <= 1'b0;
            stat_q <= '0;
            data_available_flag_q <= 1'b0;
            sync1_q <= 8'hFF;
            sync2_q <= 8'hFF;
            sync3_q <= 8'hFF;
            pin_q <= 8'hFF;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_idx_q <= 8'h00;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rresp_q <= 2'b00;
            rdata_q <= 8'h00;
            clear_q <= 12'h000;
            oe_q <= 8'h00;
        end else begin
            adc_cfg_q <= adc_cfg_d;
            falarm_q <= falarm_d;
            pin_fn_q <= pin_fn_d;
            mux2_q <= mux2_d;
            clren_q <= clren_d;
            clrsrc_q <= clrsrc_d;
            pinsrc_q <= pinsrc_d;
            latch_dis_q <= latch_dis_d;
            range_q <= range_d;
            gpio_wr_q <= gpio_wr_d;
            dac_q <= dac_d;
            adc_q <= adc_d;
            thr_up_q <= thr_up_d;
            thr_lo_q <= thr_lo_d;
            temp_q <= temp_d;
            cnt_q <= cnt_d;
            qual_q <= qual_d;
            therm_q <= therm_d;
            stat_q <= stat_d;
            data_available_flag_q <= data_available_flag_d;
            sync1_q <= i_gpio;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q <= pin_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_idx_q <= aw_idx_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            clear_q <= clear_d;
            oe_q <= oe_d;
        end
    end

    // ready flags are the inverse of held-state flops
    assign o_awready = !aw_have_q;
    assign o_wready = !w_have_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = !rvalid_q;
    assign o_rvalid = rvalid_q;
    assign o_rresp = rresp_q;
    assign o_rdata = {24'h000000, rdata_q};
    assign o_output_code = dac_q;
    assign o_output_clear = clear_q;
    assign o_group_half_range = range_q;
    assign o_temp_sensor_en = mux2_q[`MASH_MUX2_TEMP_EN];
    // pins only ever pull low
    assign o_gpio = 8'h00;
    assign o_gpio_oe = oe_q;
endmodule // mash_regs

// file: shared/mash_defs.svh
`ifndef MASH_DEFS_SVH
`define MASH_DEFS_SVH
`define MASH_IDX_ADC_CFG 8'h10
`define MASH_IDX_FALARM 8'h11
`define MASH_IDX_PIN_FN 8'h12
`define MASH_IDX_MUX2 8'h15
`define MASH_IDX_CLREN0 8'h18
`define MASH_IDX_CLREN1 8'h19
`define MASH_IDX_CLRSRC0 8'h1A
`define MASH_IDX_CLRSRC1 8'h1B
`define MASH_IDX_PINSRC0 8'h1C
`define MASH_IDX_PINSRC1 8'h1D
`define MASH_IDX_RANGE 8'h1E
`define MASH_IDX_ADC_FIRST 8'h20
`define MASH_IDX_ADC_LAST 8'h41
`define MASH_IDX_DAC_FIRST 8'h50
`define MASH_IDX_DAC_LAST 8'h67
`define MASH_IDX_STAT0 8'h70
`define MASH_IDX_STAT1 8'h71
`define MASH_IDX_GEN_STAT 8'h72
`define MASH_IDX_TEMP_LO 8'h78
`define MASH_IDX_TEMP_HI 8'h79
`define MASH_IDX_GPIO 8'h7A
`define MASH_IDX_THR_FIRST 8'h80
`define MASH_IDX_THR_LAST 8'h97
`define MASH_FALARM_RESET 5'h0E
`define MASH_GPIO_RESET 8'hFF
`define MASH_THR_UP_RESET 12'hFFF
`define MASH_THR_LO_RESET 12'h000
`define MASH_TEMP_UP_RESET 12'h7FF
`define MASH_TEMP_LO_RESET 12'h800
`define MASH_PIN_ALARM_IN 0
`define MASH_PIN_ALARM_OUT 1
`define MASH_MUX2_TEMP_EN 1
`define MASH_CFG_AUTO_MODE 3
`define MASH_FIRST_MON_CHAN 5'd12
`define MASH_THERM_SET_DEGC 150
`define MASH_THERM_HYST_DEGC 8
`define MASH_TEMP_LSB_PER_DEGC 4
`endif

// file: shared/mash_pkg.sv
package mash_pkg;
    // one converter result from the input sequencer
    typedef struct packed {
        logic [4:0] chan;
        logic [11:0] code;
    } mash_sample_t;
    // alarm vector: [4:0] chan 12..16, [5] temp low, [6] temp high,
    // [7] thermal, [8] external input
    typedef logic [8:0] mash_alarm_t;
    typedef logic [8:0] mash_count_t;
endpackage

// file: verification/mash_pin_model.sv
`timescale 1ns/1ps
module mash_pin_model (
    // pin drivers
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_ext_low,
    // resolved levels
    output logic [7:0] o_level
);
    // weak pull-up wins only when nobody pulls low
    assign o_level = ~(i_oe | i_ext_low);
endmodule // mash_pin_model

// file: verification/mash_regs_monitor.sv
`timescale 1ns/1ps
module mash_regs_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // bus
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    // outputs
    input wire logic [7:0] o_gpio,
    input wire logic [7:0] o_gpio_oe,
    input wire logic [11:0] o_output_clear,
    input wire logic [3:0] o_group_half_range
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    rd_answer_a:
        assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read not answered next cycle");
    rd_hold_a:
        assert property (o_rvalid && !i_rready
            |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped before taken");
    rd_pad_a:
        assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    ar_block_a:
        assert property (o_rvalid |-> !o_arready)
        else $error("address accepted while data pending");
    wr_hold_a:
        assert property (o_bvalid && !i_bready
            |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    pin_low_a:
        assert property (o_gpio == 8'h00)
        else $error("pin driven high");
    rst_clear_a:
        assert property ($rose(i_reset_n) |->
            o_output_clear == 12'h000 && o_gpio_oe == 8'h00)
        else $error("outputs not cleared by reset");
    range_wr_a:
        assert property ($changed(o_group_half_range) |-> $rose(o_bvalid))
        else $error("range changed without a write");
endmodule // mash_regs_monitor

bind mash_regs mash_regs_monitor mash_regs_monitor_i (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_rdata(o_rdata),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .o_bresp(o_bresp),
    .o_gpio(o_gpio),
    .o_gpio_oe(o_gpio_oe),
    .o_output_clear(o_output_clear),
    .o_group_half_range(o_group_half_range)
);

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top import mash_pkg::*;;
    logic i_clk, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_temp_sensor_en;
    logic [9:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0] i_wstrb, o_group_half_range;
    logic [1:0] o_bresp, o_rresp;
    logic i_adc_valid, i_temp_valid, i_seq_start, i_seq_done;
    mash_sample_t i_adc_sample;
    logic [11:0] i_temp_code, o_output_clear;
    logic [11:0] o_output_code [12];
    logic [7:0] i_gpio, o_gpio, o_gpio_oe, ext_low;
    int num_errors, checked;
    mash_regs mash_regs_i (.*);
    mash_pin_model mash_pin_model_i (.i_oe(o_gpio_oe), .i_ext_low(ext_low),
        .o_level(i_gpio));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, d, input logic [1:0] r = 2'h0);
        @(posedge i_clk);
        i_awaddr <= {a, 2'b00};
        i_wdata <= {24'h000000, d};
        {i_awvalid, i_wvalid, i_bready} <= 3'h7;
        while (o_bvalid !== 1'b1) begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end
        chk("bresp", {30'h0, o_bresp}, {30'h0, r});
        i_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e, input logic [1:0] r = 2'h0);
        @(posedge i_clk);
        i_araddr <= {a, 2'b00};
        {i_arvalid, i_rready} <= 2'h3;
        do begin
            @(posedge i_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        chk("rdata", o_rdata, {24'h000000, e});
        chk("rresp", {30'h0, o_rresp}, {30'h0, r});
        i_rready <= 1'b0;
    endtask
    task automatic smp(input logic [11:0] v, input int n = 1);
        repeat (n) begin
            @(posedge i_clk);
            i_adc_valid <= 1'b1;
            i_adc_sample <= '{chan: 5'h0C, code: v};
            @(posedge i_clk);
            i_adc_valid <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
    endtask
    task automatic tmp(input logic [11:0] v);
        @(posedge i_clk);
        i_temp_valid <= 1'b1;
        i_temp_code <= v;
        @(posedge i_clk);
        i_temp_valid <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
    // one-cycle sequence end (1) or start (0) pulse
    task automatic seq(input logic done);
        i_seq_done <= done;
        i_seq_start <= !done;
        @(posedge i_clk);
        {i_seq_done, i_seq_start} <= 2'h0;
    endtask
    task automatic rst();
        i_reset_n <= 1'b0;
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        {i_adc_valid, i_temp_valid, i_seq_start, i_seq_done} = 4'h0;
        {i_awaddr, i_araddr, i_wdata, i_temp_code} = '0;
        i_adc_sample = '0;
        i_wstrb = 4'hF;
        ext_low = 8'h00;
        i_reset_n = 1'b0;
        rst();
        rd(8'h7A, 8'hFF);
        rd(8'h01, 8'h00, 2'h2);
        wr(8'h01, 8'hFF, 2'h2);
        seq(1'b1);
        rd(8'h72, 8'h01);
        seq(1'b0);
        rd(8'h72, 8'h00);
        wr(8'h10, 8'h80);
        seq(1'b1);
        rd(8'h72, 8'h00);
        wr(8'h10, 8'h00);
        foreach (i_wdata[k]) if (k < 5) begin
            wr(8'h1A + 8'(k), 8'hFF);
            rd(8'h1A + 8'(k), (k % 3 == 1) ? 8'h0F : 8'h1F);
            wr(8'h1A + 8'(k), 8'h00);
        end
        wr(8'h50, 8'hAB);
        wr(8'h51, 8'hFC);
        rd(8'h51, 8'h0C);
        chk("code0", {20'h0, o_output_code[0]}, 32'hCAB);
        @(posedge i_clk);
        i_adc_valid <= 1'b1;
        i_adc_sample <= '{chan: 5'h03, code: 12'h5A7};
        i_temp_valid <= 1'b1;
        i_temp_code <= 12'h9C3;
        @(posedge i_clk);
        {i_adc_valid, i_temp_valid} <= 2'h0;
        rd(8'h26, 8'hA7);
        rd(8'h27, 8'h05);
        rd(8'h78, 8'hC3);
        rd(8'h79, 8'h09);
        wr(8'h7A, 8'hF0);
        ext_low <= 8'h20;
        repeat (8) @(posedge i_clk);
        rd(8'h7A, 8'hD0);
        wr(8'h7A, 8'hFF);
        ext_low <= 8'h00;
        wr(8'h11, 8'h00);
        wr(8'h80, 8'h00);
        wr(8'h81, 8'h01);
        smp(12'h200);
        rd(8'h72, 8'h02);
        wr(8'h1A, 8'h01);
        wr(8'h18, 8'hFF);
        wr(8'h1C, 8'h01);
        chk("pin1 idle", {31'h0, o_gpio_oe[1]}, 32'h0);
        wr(8'h12, 8'h02);
        repeat (2) @(posedge i_clk);
        chk("pin1 on", {31'h0, o_gpio_oe[1]}, 32'h1);
        chk("cleared", {31'h0, |o_output_clear}, 32'h1);
        smp(12'h050);
        rd(8'h70, 8'h01);
        rd(8'h70, 8'h00);
        chk("clear off", {20'h0, o_output_clear}, 32'h0);
        wr(8'h11, 8'h20);
        smp(12'h200, 3);
        smp(12'h050);
        rd(8'h70, 8'h00);
        wr(8'h1D, 8'h10);
        smp(12'h200, 4);
        rd(8'h72, 8'h02);
        smp(12'h050);
        rd(8'h70, 8'h00);
        wr(8'h12, 8'h03);
        rd(8'h71, 8'h08);
        ext_low <= 8'h01;
        repeat (6) @(posedge i_clk);
        rd(8'h71, 8'h00);
        wr(8'h15, 8'h02);
        chk("sensor on", {31'h0, o_temp_sensor_en}, 32'h1);
        wr(8'h95, 8'h02);
        wr(8'h97, 8'h01);
        tmp(12'h300);
        rd(8'h71, 8'h06);
        tmp(12'h240);
        rd(8'h71, 8'h04);
        wr(8'h15, 8'h00);
        rd(8'h71, 8'h00);
        wr(8'h15, 8'h02);
        tmp(12'h0F0);
        rd(8'h71, 8'h01);
        smp(12'h200, 4);
        rst();
        rd(8'h70, 8'h00);
        rd(8'h71, 8'h00);
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        wrap_up();
    end
endmodule // tb_top
